// ### core/ucg_clock_gen.sv
// Serial clock generation unit: modes, dividers, transfer clock pin
// Summary of operation
// - Four clock modes: async normal, async double, sync master, sync slave.
// - Mode select bit zero means asynchronous, one means synchronous.
// - In sync mode pin direction out means master, in means slave.
// - Transfer clock pin neither driven nor used in asynchronous modes.
// - Internal generator serves async and master; slave uses synchronised pin.
// - Down-counter reloads divisor at zero and on divisor low write.
// - One tick per zero count: system clock over divisor plus one.
// - Transmit clock is tick (pin edge in slave mode) over 16, 8 or 2 by mode.
// - Receiver steps 16, 8 or 2 states on generator tick, or on pin edge in slave mode.
// - Divisor 0 to 4095 from high and low registers together.
// - Double speed bit only acts in async mode, 16 becomes 8.
// - Double speed gives receiver 8 samples per bit, not 16.
// - External clock passes synchronisation logic beside the generator.
// - Slave clock goes through sync register and edge detector, two cycles.
// - Polarity clear: change on rising, sample on falling; set reverses.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`default_nettype none

module ucg_clock_gen (
	input  wire logic                       mclk,
	input  wire logic                       rstn,
	input  wire logic [ucg_pkg::ADDR_W-1:0] addr,
	input  wire logic [ucg_pkg::DATA_W-1:0] wdata,
	input  wire logic                       wrStb,
	input  wire logic                       rdStb,
	output logic      [ucg_pkg::DATA_W-1:0] rdata,
	input  wire logic                       xckIn,
	output logic                            xckOut,
	output logic                            xckOe,
	output logic                            txClkTick,
	output logic                            rxClkTick,
	output logic     [ucg_pkg::PHASE_W-1:0] rxPhase,
	output logic                            dataChangeTick,
	output logic                            dataSampleTick
);

	// Whole state of the unit, baud down-counter aside, in one record
	typedef struct packed {
		logic                      syncMode;
		logic                      doubleSpeed;
		logic                      pinDirOut;
		logic                      polarity;
		logic                      powerOff;
		logic [7:0]                divLow;
		logic [3:0]                divHigh;
		logic                      reloadPend;
		logic                      xckSync1;
		logic                      xckSync2;
		logic                      xckPrev;
		logic                      xckDrive;
		logic                      xckOe;
		logic [3:0]                txCount;
		logic [3:0]                rxPhase;
		logic                      txClkTick;
		logic                      rxClkTick;
		logic                      changeTick;
		logic                      sampleTick;
		logic [7:0]                rdata;
	} ucg_gen_state_t;

	localparam ucg_gen_state_t ST_RESET = '{
		syncMode:    ucg_pkg::CTRL_RESET[ucg_pkg::CTRL_SYNC],
		doubleSpeed: ucg_pkg::CTRL_RESET[ucg_pkg::CTRL_DOUBLE],
		pinDirOut:   ucg_pkg::CTRL_RESET[ucg_pkg::CTRL_DIR_OUT],
		polarity:    ucg_pkg::CTRL_RESET[ucg_pkg::CTRL_POLARITY],
		powerOff:    ucg_pkg::CTRL_RESET[ucg_pkg::CTRL_POWER_OFF],
		divLow:      ucg_pkg::DIV_RESET[7:0],
		divHigh:     ucg_pkg::DIV_RESET[11:8],
		default:     '0
	};

	ucg_gen_state_t     st_r;
	ucg_gen_state_t     st_nxt;
	ucg_pkg::ucg_mode_t mode;
	logic [3:0]         lastStep;
	logic               extRise;
	logic               extFall;
	logic               newLvl;
	logic               isChange;

	// Mode from the three control bits
	function automatic ucg_pkg::ucg_mode_t modeOf(
		input logic sync,
		input logic dirOut,
		input logic dbl
	);
		if (sync)
			return dirOut ? ucg_pkg::MODE_SYNC_MASTER : ucg_pkg::MODE_SYNC_SLAVE;
		else
			return dbl ? ucg_pkg::MODE_ASYNC_DOUBLE : ucg_pkg::MODE_ASYNC_NORMAL;
	endfunction : modeOf

	// Highest counter value for a mode
	function automatic logic [3:0] lastPhase(input ucg_pkg::ucg_mode_t m);
		logic [4:0] ratio;
		case (m)
			ucg_pkg::MODE_ASYNC_NORMAL: ratio = ucg_pkg::RATIO_NORMAL - 5'h01;
			ucg_pkg::MODE_ASYNC_DOUBLE: ratio = ucg_pkg::RATIO_DOUBLE - 5'h01;
			default:                    ratio = ucg_pkg::RATIO_SYNC - 5'h01;
		endcase
		return ratio[3:0];
	endfunction : lastPhase

	// Wrapping step; the >= also recovers after a mode change
	function automatic logic [3:0] stepPhase(
		input logic [3:0] cur,
		input logic [3:0] last
	);
		return (cur >= last) ? 4'h0 : cur + 4'h1;
	endfunction : stepPhase

	// Baud rate generator and its link
	ucg_baud_if baud ();

	assign baud.divisor = {st_r.divHigh, st_r.divLow};
	assign baud.reload  = st_r.reloadPend;
	assign baud.enable  = !st_r.powerOff;

	ucg_baud_gen u_baud (
		.mclk (mclk),
		.rstn (rstn),
		.bus  (baud)
	);

	// Next state: register port, pin synchroniser, dividers
	always_comb
	begin
		st_nxt   = st_r;
		newLvl   = 1'b0;
		isChange = 1'b0;
		mode     = modeOf(st_r.syncMode, st_r.pinDirOut, st_r.doubleSpeed);
		lastStep = lastPhase(mode);
		extRise  = st_r.xckSync2 && !st_r.xckPrev;
		extFall  = !st_r.xckSync2 && st_r.xckPrev;

		// Register writes
		st_nxt.reloadPend = 1'b0;
		if (wrStb)
		begin
			if (addr == ucg_pkg::ADDR_CTRL)
			begin
				st_nxt.syncMode    = wdata[ucg_pkg::CTRL_SYNC];
				st_nxt.doubleSpeed = wdata[ucg_pkg::CTRL_DOUBLE];
				st_nxt.pinDirOut   = wdata[ucg_pkg::CTRL_DIR_OUT];
				st_nxt.polarity    = wdata[ucg_pkg::CTRL_POLARITY];
				st_nxt.powerOff    = wdata[ucg_pkg::CTRL_POWER_OFF];
			end
			else if (addr == ucg_pkg::ADDR_DIV_LOW)
			begin
				st_nxt.divLow     = wdata;
				st_nxt.reloadPend = 1'b1;
			end
			else if (addr == ucg_pkg::ADDR_DIV_HIGH)
			begin
				st_nxt.divHigh = wdata[3:0];
			end
		end

		// Read data stands one cycle, zero otherwise and when unmapped
		st_nxt.rdata = 8'h00;
		if (rdStb)
		begin
			if (addr == ucg_pkg::ADDR_CTRL)
			begin
				st_nxt.rdata[ucg_pkg::CTRL_SYNC]      = st_r.syncMode;
				st_nxt.rdata[ucg_pkg::CTRL_DOUBLE]    = st_r.doubleSpeed;
				st_nxt.rdata[ucg_pkg::CTRL_DIR_OUT]   = st_r.pinDirOut;
				st_nxt.rdata[ucg_pkg::CTRL_POLARITY]  = st_r.polarity;
				st_nxt.rdata[ucg_pkg::CTRL_POWER_OFF] = st_r.powerOff;
			end
			else if (addr == ucg_pkg::ADDR_DIV_LOW)
			begin
				st_nxt.rdata = st_r.divLow;
			end
			else if (addr == ucg_pkg::ADDR_DIV_HIGH)
			begin
				st_nxt.rdata[3:0] = st_r.divHigh;
			end
			else if (addr == ucg_pkg::ADDR_STATUS)
			begin
				st_nxt.rdata[ucg_pkg::STAT_PHASE +: 4] = st_r.rxPhase;
				st_nxt.rdata[ucg_pkg::STAT_MODE +: 2]  = mode;
				st_nxt.rdata[ucg_pkg::STAT_XCK]        = st_r.xckSync2;
			end
		end

		// two-stage synchroniser; first stage feeds only the second
		st_nxt.xckSync1 = xckIn;
		st_nxt.xckSync2 = st_r.xckSync1;
		st_nxt.xckPrev  = st_r.xckSync2;

		// Event outputs are single-cycle pulses
		st_nxt.txClkTick  = 1'b0;
		st_nxt.rxClkTick  = 1'b0;
		st_nxt.changeTick = 1'b0;
		st_nxt.sampleTick = 1'b0;
		st_nxt.xckOe      = (mode == ucg_pkg::MODE_SYNC_MASTER) && !st_r.powerOff;

		if (st_r.powerOff)
		begin
			// Powered down: counters parked so restart is clean
			st_nxt.txCount  = 4'h0;
			st_nxt.rxPhase  = 4'h0;
			st_nxt.xckDrive = st_r.polarity;
		end
		else
		begin
			case (mode)
				ucg_pkg::MODE_ASYNC_NORMAL,
				ucg_pkg::MODE_ASYNC_DOUBLE:
				begin
					// Idle level kept so a later master start is clean
					st_nxt.xckDrive = st_r.polarity;
					if (baud.tick)
					begin
						st_nxt.rxClkTick = 1'b1;
						st_nxt.rxPhase   = stepPhase(st_r.rxPhase, lastStep);
						st_nxt.txCount   = stepPhase(st_r.txCount, lastStep);
						st_nxt.txClkTick = (st_r.txCount >= lastStep);
					end
				end
				ucg_pkg::MODE_SYNC_MASTER:
				begin
					if (baud.tick)
					begin
						newLvl          = !st_r.xckDrive;
						st_nxt.xckDrive = newLvl;
						isChange          = newLvl ^ st_r.polarity;
						st_nxt.changeTick = isChange;
						st_nxt.sampleTick = !isChange;
						st_nxt.txClkTick  = isChange;
						st_nxt.txCount    = 4'h0;
						st_nxt.rxClkTick  = 1'b1;
						st_nxt.rxPhase    = stepPhase(st_r.rxPhase, lastStep);
					end
				end
				default:
				begin
					st_nxt.xckDrive = st_r.polarity;
					if (extRise || extFall)
					begin
						isChange          = st_r.polarity ? extFall : extRise;
						st_nxt.changeTick = isChange;
						st_nxt.sampleTick = !isChange;
						st_nxt.txClkTick  = isChange;
						st_nxt.txCount    = 4'h0;
						st_nxt.rxClkTick  = 1'b1;
						st_nxt.rxPhase    = stepPhase(st_r.rxPhase, lastStep);
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			st_r <= ST_RESET;
		else
			st_r <= st_nxt;
	end

	// Outputs straight from the state register
	assign rdata          = st_r.rdata;
	assign xckOut         = st_r.xckDrive;
	assign xckOe          = st_r.xckOe;
	assign txClkTick      = st_r.txClkTick;
	assign rxClkTick      = st_r.rxClkTick;
	assign rxPhase        = st_r.rxPhase;
	assign dataChangeTick = st_r.changeTick;
	assign dataSampleTick = st_r.sampleTick;

	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	logic asyncOn;
	logic masterOn;
	logic slaveLow;
	assign asyncOn  = !st_r.syncMode && !st_r.powerOff;
	assign masterOn = (mode == ucg_pkg::MODE_SYNC_MASTER) && !st_r.powerOff;
	assign slaveLow = (mode == ucg_pkg::MODE_SYNC_SLAVE) && !st_r.powerOff && !st_r.polarity;

	async_pin_idle_a: assert property (!st_r.syncMode |=> !xckOe)
		else $error("pin driven in asynchronous mode");

	master_drives_a: assert property (masterOn |=> xckOe)
		else $error("master mode not driving pin");

	master_toggle_a: assert property (masterOn && baud.tick |=> xckOut != $past(xckOut))
		else $error("pin did not toggle on generator tick");

	pin_edge_role_a: assert property (
		masterOn && baud.tick && (xckOut == st_r.polarity) |=> dataChangeTick && !dataSampleTick)
		else $error("change edge does not follow polarity");

	rx_base_tick_a: assert property (asyncOn && baud.tick |=> rxClkTick)
		else $error("receiver missed generator tick");

	double_tx_wrap_a: assert property (
		asyncOn && st_r.doubleSpeed && baud.tick && st_r.txCount == 4'h7 |=> txClkTick && st_r.txCount == 4'h0)
		else $error("double speed transmit divide is not eight");

	normal_tx_mid_a: assert property (
		asyncOn && !st_r.doubleSpeed && baud.tick && st_r.txCount == 4'h7 |=> !txClkTick)
		else $error("normal mode transmit divide is not sixteen");

	double_rx_range_a: assert property (asyncOn && st_r.doubleSpeed && baud.tick |=> rxPhase <= 4'h7)
		else $error("receiver exceeds eight states at double speed");

	slave_delay_a: assert property (
		$rose(xckIn) && slaveLow ##1 slaveLow [*2] |=> dataChangeTick)
		else $error("slave rising edge not seen after sync delay");

	master_cover: cover property (masterOn && dataChangeTick);
	slave_cover: cover property (slaveLow && dataSampleTick);
	double_cover: cover property (asyncOn && st_r.doubleSpeed && txClkTick);
	normal_cover: cover property (asyncOn && !st_r.doubleSpeed && txClkTick);

endmodule : ucg_clock_gen

`default_nettype wire

// ### core/ucg_pkg.sv
// Constants and types shared by the serial clock generation unit
`default_nettype none

package ucg_pkg;

	// Widths
	localparam int DATA_W     = 8;
	localparam int ADDR_W     = 4;
	localparam int DIV_W      = 12;
	localparam int DIV_HIGH_W = 4;
	localparam int PHASE_W    = 4;

	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_DIV_LOW  = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_DIV_HIGH = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h3;

	// Control register field positions
	localparam int CTRL_SYNC      = 0;
	localparam int CTRL_DOUBLE    = 1;
	localparam int CTRL_DIR_OUT   = 2;
	localparam int CTRL_POLARITY  = 3;
	localparam int CTRL_POWER_OFF = 4;

	// Status register field positions
	localparam int STAT_PHASE = 0;
	localparam int STAT_MODE  = 4;
	localparam int STAT_XCK   = 6;

	// Values after reset
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [DIV_W-1:0]  DIV_RESET  = 12'h000;

	// Generator ticks per transmitter clock, and receiver states
	localparam logic [PHASE_W:0] RATIO_NORMAL = 5'h10;
	localparam logic [PHASE_W:0] RATIO_DOUBLE = 5'h08;
	localparam logic [PHASE_W:0] RATIO_SYNC   = 5'h02;

	// Clock modes
	typedef enum logic [1:0] {
		MODE_ASYNC_NORMAL,
		MODE_ASYNC_DOUBLE,
		MODE_SYNC_MASTER,
		MODE_SYNC_SLAVE
	} ucg_mode_t;

endpackage : ucg_pkg

`default_nettype wire

// ### core/ucg_baud_if.sv
// Link between the clock unit and its baud rate down-counter
`default_nettype none

interface ucg_baud_if;
	logic [ucg_pkg::DIV_W-1:0] divisor;
	logic                      reload;
	logic                      enable;
	logic                      tick;

	modport ctrl (output divisor, output reload, output enable, input tick);
	modport gen  (input divisor, input reload, input enable, output tick);
endinterface : ucg_baud_if

`default_nettype wire

// ### core/ucg_baud_gen.sv
// Baud rate generator: reloading down-counter on the system clock
`default_nettype none

module ucg_baud_gen (
	input  wire logic mclk,
	input  wire logic rstn,
	ucg_baud_if.gen   bus
);

	typedef struct packed {
		logic [ucg_pkg::DIV_W-1:0] count;
		logic                      tick;
	} ucg_baud_state_t;

	localparam ucg_baud_state_t ST_RESET = '{count: ucg_pkg::DIV_RESET, tick: 1'b0};

	ucg_baud_state_t st_r;
	ucg_baud_state_t st_nxt;

	// Count down; a zero count emits a tick and reloads
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.tick = bus.enable && (st_r.count == 12'h000);
		if (!bus.enable || bus.reload || st_r.count == 12'h000)
			st_nxt.count = bus.divisor;
		else
			st_nxt.count = st_r.count - 12'h001;
	end

	// State register
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			st_r <= ST_RESET;
		else
			st_r <= st_nxt;
	end

	assign bus.tick = st_r.tick;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	low_write_reload_a: assert property (bus.reload |=> st_r.count == $past(bus.divisor))
		else $error("counter did not reload after divisor write");

	zero_count_tick_a: assert property (bus.enable && st_r.count == 12'h000 |=> bus.tick)
		else $error("no tick after counter reached zero");

	midway_no_tick_a: assert property (st_r.count != 12'h000 |=> !bus.tick)
		else $error("tick emitted with nonzero count");

endmodule : ucg_baud_gen

`default_nettype wire

// ### verif/ucg_peer_model.sv
// Remote serial peer that clocks the transfer clock pin in slave mode
`default_nettype none

module ucg_peer_model (
	input  wire logic       mclk,
	input  wire logic       start,
	input  wire logic [3:0] halfCyc,
	input  wire logic [4:0] nEdges,
	input  wire logic       idleLvl,
	output logic            pin,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] cnt;
	logic [4:0] left;

	initial
	begin
		pin = 1'b0;
		busy = 1'b0;
	end

	// slow enough edges: callers keep halfCyc at four or more
	always @(posedge mclk)
	begin
		if (!busy)
		begin
			pin <= idleLvl;
			cnt <= 4'h0;
			left <= nEdges;
			busy <= start;
		end
		else if (cnt == halfCyc - 4'h1)
		begin
			pin <= ~pin;
			cnt <= 4'h0;
			left <= left - 5'h01;
			busy <= (left != 5'h01);
		end
		else
			cnt <= cnt + 4'h1;
	end
endmodule : ucg_peer_model

`default_nettype wire

// ### verif/ucg_clock_gen_tb_top.sv
// Self-checking bench for the serial clock generation unit
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end

module ucg_clock_gen_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic                         mclk, rstn, wrStb, rdStb, xckIn, xckOut, xckOe;
	logic                         txClkTick, rxClkTick, dataChangeTick, dataSampleTick;
	logic [ucg_pkg::ADDR_W-1:0]   addr;
	logic [ucg_pkg::DATA_W-1:0]   wdata, rdata;
	logic [ucg_pkg::PHASE_W-1:0]  rxPhase;
	logic                         pEn, pStart, pPin, pBusy, pol, lastPin, relPat;
	logic [3:0]                   pHalf;
	int                           n_fail = 0, cmp_count = 0, since = 0;
	int                           nRx = 0, nTx = 0, nChg = 0, nSmp = 0, nOe = 0;
	// sync entries keep double speed cleared
	logic [7:0]                   modeTbl [5] = '{8'h00, 8'h02, 8'h06, 8'h05, 8'h0d};

	ucg_clock_gen u_ucg_clock_gen (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wrStb(wrStb),
		.rdStb(rdStb), .rdata(rdata), .xckIn(xckIn), .xckOut(xckOut), .xckOe(xckOe), .txClkTick(txClkTick),
		.rxClkTick(rxClkTick), .rxPhase(rxPhase), .dataChangeTick(dataChangeTick),
		.dataSampleTick(dataSampleTick));

	ucg_peer_model u_ucg_peer_model (.mclk(mclk), .start(pStart), .halfCyc(pHalf), .nEdges(5'h10),
		.idleLvl(pol), .pin(pPin), .busy(pBusy));

	// Released pin wanders every cycle so stale levels never look valid
	always @(posedge mclk) relPat <= ~relPat;
	assign xckIn = xckOe ? xckOut : (pEn ? pPin : relPat);

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Pulse tallies and slave edge timing
	always @(negedge mclk)
	begin
		nRx <= nRx + int'(rxClkTick === 1'b1);
		nTx <= nTx + int'(txClkTick === 1'b1);
		nChg <= nChg + int'(dataChangeTick === 1'b1);
		nSmp <= nSmp + int'(dataSampleTick === 1'b1);
		nOe <= nOe + int'(xckOe === 1'b1);
		since <= (pPin !== lastPin) ? 0 : since + 1;
		lastPin <= pPin;
		if (pEn && (dataChangeTick | dataSampleTick) === 1'b1)
		begin
			`CHK(since, 2)
			`CHK(pPin, dataChangeTick ? ~pol : pol)
		end
	end

	task automatic wr(input int a, input logic [ucg_pkg::DATA_W-1:0] d);
		@(posedge mclk);
		addr <= 4'(a);
		wdata <= d;
		wrStb <= 1'b1;
		@(posedge mclk);
		wrStb <= 1'b0;
	endtask : wr

	task automatic rd(input int a, output logic [ucg_pkg::DATA_W-1:0] d);
		@(posedge mclk);
		addr <= 4'(a);
		rdStb <= 1'b1;
		@(posedge mclk);
		rdStb <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask : rd

	function automatic logic sig(input int s);
		case (s)
			0: return rxClkTick;
			1: return txClkTick;
			default: return dataChangeTick;
		endcase
	endfunction : sig

	// Cycles between two pulses; a hang shows as an oversized count
	task automatic gap(input int s, output int n);
		n = 0;
		while (sig(s) !== 1'b1 && n < 9000)
		begin
			@(negedge mclk);
			n++;
		end
		n = 0;
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (sig(s) !== 1'b1 && n < 9000);
	endtask : gap

	task automatic phTop(input int cyc, output int m);
		m = 0;
		repeat (cyc)
		begin
			@(negedge mclk);
			if (int'(rxPhase) > m)
				m = int'(rxPhase);
		end
	endtask : phTop

	function automatic int ratio(input logic [7:0] c);
		return c[0] ? 2 : (c[1] ? 8 : 16);
	endfunction : ratio

	function automatic logic [1:0] modeOf(input logic [7:0] c);
		return c[0] ? {1'b1, ~c[2]} : {1'b0, c[1]};
	endfunction : modeOf

	task automatic results;
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	// Watchdog, well past the expected run length
	initial
	begin
		#2ms;
		n_fail++;
		results();
	end

	initial
	begin
		logic [7:0] d, c;
		int n, m, dv, s0, s1, s2;
		void'($urandom(32'h36b0728e));
		{rstn, addr, wdata, wrStb, rdStb, pEn, pStart, pol, lastPin, relPat} = '0;
		pHalf = 4'h4;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		// control, divisor and unmapped places read zero after reset
		foreach (modeTbl[i])
		begin
			rd(i == 3 ? 9 : i, d);
			if (i < 4)
				`CHK(d, 8'h00)
		end
		// each internal mode with a random divisor
		foreach (modeTbl[i])
		begin
			c = modeTbl[i];
			dv = $urandom_range(7, 0);
			wr(2, 8'h00);
			wr(1, 8'(dv));
			wr(0, c);
			rd(3, d);
			`CHK(d[5:4], modeOf(c))
			gap(0, n);
			`CHK(n, dv + 1)
			gap(1, n);
			`CHK(n, ratio(c) * (dv + 1))
			s0 = nChg + nSmp;
			phTop(ratio(c) * (dv + 1) * 3, m);
			`CHK(m, ratio(c) - 1)
			`CHK(xckOe, c[0] & c[2])
			if (!c[0])
				`CHK(nChg + nSmp - s0, 0)
			else
			begin
				gap(2, n);
				`CHK(n, 2 * (dv + 1))
				`CHK(xckOut, ~c[3])
			end
		end
		// a low write restarts the count from any phase
		wr(0, 8'h00);
		// Long divisor so the old count cannot tick before the reload
		wr(1, 8'hc8);
		repeat (2)
		begin
			dv = $urandom_range(150, 100);
			gap(0, n);
			repeat ($urandom_range(40, 2)) @(posedge mclk);
			wr(1, 8'(dv));
			n = 0;
			do
			begin
				@(negedge mclk);
				n++;
			end
			while (rxClkTick !== 1'b1 && n < 400);
			`CHK(n, dv + 4)
		end
		// largest divisor, high part four bits wide
		wr(2, 8'hff);
		wr(1, 8'hff);
		rd(2, d);
		`CHK(d, 8'h0f)
		gap(0, n);
		`CHK(n, 4096)
		// power-off bit keeps the unit idle
		wr(0, 8'h15);
		{s0, s1, s2} = {nRx, nTx, nOe};
		repeat (200) @(negedge mclk);
		`CHK(nRx + nTx + nOe - s0 - s1 - s2, 0)
		// slave mode with double speed cleared, both polarities
		for (int p = 0; p < 2; p++)
		begin
			// Pin level settles while powered off, so no false edge reaches slave mode
			wr(0, 8'h15);
			@(posedge mclk);
			pol <= 1'(p);
			pEn <= 1'b1;
			pHalf <= 4'($urandom_range(7, 4));
			repeat (4) @(posedge mclk);
			wr(0, p ? 8'h09 : 8'h01);
			rd(3, d);
			`CHK(d[5:4], 2'h3)
			{s0, s1, s2} = {nRx, nTx, nChg};
			m = nSmp;
			@(posedge mclk);
			pStart <= 1'b1;
			@(posedge mclk);
			pStart <= 1'b0;
			// Busy shows one edge after the start is taken
			@(posedge mclk);
			n = 0;
			while (pBusy !== 1'b0 && n < 300)
			begin
				@(posedge mclk);
				n++;
			end
			repeat (10) @(posedge mclk);
			`CHK(nChg - s2, 8)
			`CHK(nSmp - m, 8)
			`CHK(nRx - s0, 16)
			`CHK(nTx - s1, 8)
			`CHK(xckOe, 1'b0)
		end
		wr(0, 8'h00);
		@(posedge mclk);
		pEn <= 1'b0;
		// second reset in mid-run clears the divisor
		rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		rd(1, d);
		`CHK(d, 8'h00)
		results();
	end
endmodule : ucg_clock_gen_tb_top

`default_nettype wire
